//--- logic/trc_ctrl.sv
// Purpose: Transceiver reconfiguration control: analog writes/reads, word streaming, packed words
// Assumes: All inputs come from logic on core_clk; requests are one-cycle strobes
// Notes: Requests while busy, or read and write together, are ignored
//
// Contract
// - Swing write port: 3 bits per channel
// - Pre-emphasis write port: 5 bits per channel
// - DC gain write port: 2 bits per channel
// - Equalizer write port: 4 bits per channel
// - Fields ascend by channel, channel 0 lowest
// - Readback always separate per-channel fields
// - Per-channel write updates all channels together
// - Read identical in either write mode
// - Direction select picks transmit, receive or both
// - Channel reconfig touches coding only, analog settings kept
// - Channel reconfig mode: writes only, no reads
// - Image sent as 16-bit words, continuous option
// - Packed transmit word: 22 bits per channel
// - Packed receive word: 32 bits per channel
// - 8-bit interface transmit word field map
// - 10-bit interface: data in bits 9:0
// - 16-bit interface: bytes 7:0 and 18:11
// - 16-bit disparity flags, PCIe variants
// - 20-bit interface: symbols 9:0 and 20:11
// - Busy high during transaction, low after
// - Data valid after read completes
// - Direction 2'b10 limits to transmit settings
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "trc_defines.svh"
module trc_ctrl
  import trc_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter bit PER_CH_WR = 1'b1,
  parameter bit CONT_WR = 1'b1,
  parameter int IMG_AW = 6
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic write_all,
  input wire logic read,
  input wire logic [1:0] dir_sel,
  input wire logic chan_reconfig_mode,
  input wire logic [`TRC_SWING_W*NUM_CH-1:0] swing_wr,
  input wire logic [`TRC_PREEMP_W*NUM_CH-1:0] preemp_wr,
  input wire logic [`TRC_DCGAIN_W*NUM_CH-1:0] dcgain_wr,
  input wire logic [`TRC_EQCTL_W*NUM_CH-1:0] eqctl_wr,
  output logic [`TRC_SWING_W*NUM_CH-1:0] swing_rd,
  output logic [`TRC_PREEMP_W*NUM_CH-1:0] preemp_rd,
  output logic [`TRC_DCGAIN_W*NUM_CH-1:0] dcgain_rd,
  output logic [`TRC_EQCTL_W*NUM_CH-1:0] eqctl_rd,
  output logic busy,
  output logic data_valid,
  output trc_pma_t [NUM_CH-1:0] pma_set,
  input wire logic img_we,
  input wire logic [IMG_AW-1:0] img_addr,
  input wire logic [`TRC_CFG_WORD_W-1:0] img_data,
  input wire logic [IMG_AW:0] img_len,
  output logic [`TRC_CFG_WORD_W-1:0] cfg_word,
  output logic [IMG_AW-1:0] cfg_word_idx,
  output logic cfg_word_valid,
  output logic cfg_done,
  input wire logic [`TRC_TXP_W*NUM_CH-1:0] tx_packed,
  input wire trc_fabric_w_t fabric_w,
  input wire logic pcie_mode,
  output trc_txw_t [NUM_CH-1:0] txw_out,
  input wire logic [`TRC_RXP_W*NUM_CH-1:0] rx_chan_word,
  output logic [`TRC_RXP_W*NUM_CH-1:0] rx_packed
);

  localparam int WR_TOT = `TRC_WR_CYC_PER_CH * NUM_CH;
  localparam int RD_TOT = `TRC_RD_CYC_PER_CH * NUM_CH;
  localparam int CNT_W = 8;
  localparam int AST_MAXW = 255;

  // Packed transmit word decode by fabric width
  function automatic trc_txw_t decode_txw(input logic [`TRC_TXP_W-1:0] w, input trc_fabric_w_t fw,
                                          input logic pcie);
    trc_txw_t r;
    r = '0;
    unique case (fw)
      TRC_FW_8: begin
        r.data[7:0] = w[7:0];
        r.ctrl[0] = w[`TRC_TXP_CTRL_LO];
        r.force_disp[0] = pcie ? 1'b0 : w[`TRC_TXP_FDISP_LO];
        r.compliance = pcie ? w[`TRC_TXP_FDISP_LO] : 1'b0;
        r.disp_val[0] = pcie ? 1'b0 : w[`TRC_TXP_DVAL_LO];
        r.elec_idle = pcie ? w[`TRC_TXP_DVAL_LO] : 1'b0;
      end
      TRC_FW_10: begin
        r.data[9:0] = w[9:0];
      end
      TRC_FW_16: begin
        r.data[7:0] = w[7:0];
        r.data[15:8] = w[`TRC_TXP_HI8_MSB:`TRC_TXP_HI_LSB];
        r.ctrl = {w[`TRC_TXP_CTRL_HI], w[`TRC_TXP_CTRL_LO]};
        if (pcie) begin
          r.compliance = w[`TRC_TXP_FDISP_LO];
          r.elec_idle = w[`TRC_TXP_DVAL_LO] | w[`TRC_TXP_DVAL_HI];
        end else begin
          r.force_disp = {w[`TRC_TXP_FDISP_HI], w[`TRC_TXP_FDISP_LO]};
          r.disp_val = {w[`TRC_TXP_DVAL_HI], w[`TRC_TXP_DVAL_LO]};
        end
      end
      TRC_FW_20: begin
        r.data[9:0] = w[9:0];
        r.data[19:10] = w[`TRC_TXP_HI10_MSB:`TRC_TXP_HI_LSB];
      end
    endcase
    return r;
  endfunction : decode_txw

  trc_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] dir_ff;
  trc_pma_t [NUM_CH-1:0] wr_lat_ff;
  trc_pma_t [NUM_CH-1:0] pma_ff;
  trc_pma_t [NUM_CH-1:0] wr_fields;
  logic valid_ff;
  logic [`TRC_CFG_WORD_W-1:0] img_mem [0:(1<<IMG_AW)-1];
  logic [IMG_AW-1:0] idx_ff;
  logic [`TRC_CFG_WORD_W-1:0] word_ff;
  logic [IMG_AW-1:0] word_idx_ff;
  logic word_vld_ff;
  logic done_ff;
  trc_txw_t [NUM_CH-1:0] txw_ff;
  logic [`TRC_RXP_W*NUM_CH-1:0] rxp_ff;

  wire idle = (state_ff == TRC_ST_IDLE);
  wire one_req = write_all ^ read;
  wire wr_acc = idle && one_req && write_all && !chan_reconfig_mode;
  wire rd_acc = idle && one_req && read && !chan_reconfig_mode;
  wire strm_acc = idle && one_req && write_all && chan_reconfig_mode && (img_len != '0);
  wire cnt_zero = (cnt_ff == '0);
  wire wr_done = (state_ff == TRC_ST_WR) && cnt_zero;
  wire rd_done = (state_ff == TRC_ST_RD) && cnt_zero;
  wire last_word = ({1'b0, idx_ff} == img_len - 1'b1);
  wire strm_step = (state_ff == TRC_ST_STRM);
  wire do_tx = dir_ff[1];
  wire do_rx = dir_ff[0];

  // Split write ports into ascending per-channel fields
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      localparam int SRC = PER_CH_WR ? g : 0;
      assign wr_fields[g].swing = swing_wr[SRC*`TRC_SWING_W +: `TRC_SWING_W];
      assign wr_fields[g].preemp = preemp_wr[SRC*`TRC_PREEMP_W +: `TRC_PREEMP_W];
      assign wr_fields[g].dcgain = dcgain_wr[SRC*`TRC_DCGAIN_W +: `TRC_DCGAIN_W];
      assign wr_fields[g].eqctl = eqctl_wr[SRC*`TRC_EQCTL_W +: `TRC_EQCTL_W];
    end
  endgenerate

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      TRC_ST_IDLE: begin
        if (wr_acc) begin
          nxt_state = TRC_ST_WR;
          nxt_cnt = CNT_W'(WR_TOT - 1);
        end else if (rd_acc) begin
          nxt_state = TRC_ST_RD;
          nxt_cnt = CNT_W'(RD_TOT - 1);
        end else if (strm_acc) begin
          nxt_state = TRC_ST_STRM;
        end
      end
      TRC_ST_WR, TRC_ST_RD: begin
        if (cnt_zero) begin
          nxt_state = TRC_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      TRC_ST_STRM: begin
        if (last_word || !CONT_WR) begin
          nxt_state = TRC_ST_IDLE;
        end
      end
      default: nxt_state = TRC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= TRC_ST_IDLE;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Capture request data at acceptance
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dir_ff <= `TRC_DIR_DUPLEX;
      wr_lat_ff <= '0;
    end else if (wr_acc || rd_acc) begin
      dir_ff <= dir_sel;
      wr_lat_ff <= wr_fields;
    end
  end

  // Channel analog settings, all channels at once
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pma_ff <= {NUM_CH{`TRC_PMA_RST}};
    end else if (wr_done) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (do_tx) begin
          pma_ff[c].swing <= wr_lat_ff[c].swing;
          pma_ff[c].preemp <= wr_lat_ff[c].preemp;
        end
        if (do_rx) begin
          pma_ff[c].dcgain <= wr_lat_ff[c].dcgain;
          pma_ff[c].eqctl <= wr_lat_ff[c].eqctl;
        end
      end
    end
  end

  // Readback, same in both write modes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      swing_rd <= '0;
      preemp_rd <= '0;
      dcgain_rd <= '0;
      eqctl_rd <= '0;
    end else if (rd_done) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (do_tx) begin
          swing_rd[c*`TRC_SWING_W +: `TRC_SWING_W] <= pma_ff[c].swing;
          preemp_rd[c*`TRC_PREEMP_W +: `TRC_PREEMP_W] <= pma_ff[c].preemp;
        end
        if (do_rx) begin
          dcgain_rd[c*`TRC_DCGAIN_W +: `TRC_DCGAIN_W] <= pma_ff[c].dcgain;
          eqctl_rd[c*`TRC_EQCTL_W +: `TRC_EQCTL_W] <= pma_ff[c].eqctl;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      valid_ff <= 1'b0;
    end else if (rd_done) begin
      valid_ff <= 1'b1;
    end else if (wr_acc || rd_acc || strm_acc) begin
      valid_ff <= 1'b0;
    end
  end

  // Configuration image store
  always_ff @(posedge core_clk) begin
    if (img_we) begin
      img_mem[img_addr] <= img_data;
    end
  end

  // Word streaming to the channel's coding layer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idx_ff <= '0;
      word_ff <= '0;
      word_idx_ff <= '0;
      word_vld_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      word_vld_ff <= strm_step;
      done_ff <= strm_step && last_word;
      if (strm_step) begin
        word_ff <= img_mem[idx_ff];
        word_idx_ff <= idx_ff;
        idx_ff <= last_word ? '0 : IMG_AW'(idx_ff + 1'b1);
      end
    end
  end

  // Packed channel words
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txw_ff <= '0;
      rxp_ff <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        txw_ff[c] <= decode_txw(tx_packed[c*`TRC_TXP_W +: `TRC_TXP_W], fabric_w, pcie_mode);
      end
      rxp_ff <= rx_chan_word;
    end
  end

  assign busy = !idle;
  assign data_valid = valid_ff;
  assign pma_set = pma_ff;
  assign cfg_word = word_ff;
  assign cfg_word_idx = word_idx_ff;
  assign cfg_word_valid = word_vld_ff;
  assign cfg_done = done_ff;
  assign txw_out = txw_ff;
  assign rx_packed = rxp_ff;

  sequence s_wr_start;
    idle && write_all && !read && !chan_reconfig_mode;
  endsequence

  sequence s_rd_start;
    idle && read && !write_all && !chan_reconfig_mode;
  endsequence

  AST_WR_BUSY: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_wr_start |=> busy ##[1:AST_MAXW] !busy)
    else $error("write did not raise then drop busy");

  AST_RD_VALID: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_rd_start |=> !data_valid ##[1:AST_MAXW] (!busy && data_valid))
    else $error("read did not end with data valid");

  AST_NO_CR_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
    (idle && read && chan_reconfig_mode) |=> !busy)
    else $error("read accepted in channel reconfiguration mode");

  AST_ALL_CH_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_done && do_tx) |=> (pma_set[0].swing == $past(wr_lat_ff[0].swing))
      && (pma_set[NUM_CH-1].preemp == $past(wr_lat_ff[NUM_CH-1].preemp)))
    else $error("write did not update every channel");

  AST_TX_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_done && dir_ff == `TRC_DIR_TX) |=> $stable(pma_set[0].eqctl) && $stable(pma_set[0].dcgain))
    else $error("transmit-only write changed receive settings");

  AST_RB_FIELDS: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_done && do_rx) |=> (eqctl_rd[`TRC_EQCTL_W*NUM_CH-1 -: `TRC_EQCTL_W] == pma_set[NUM_CH-1].eqctl))
    else $error("readback field mismatch on last channel");

  AST_CONT_STREAM: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strm_acc && CONT_WR && img_len > 1) |=> strm_step [*2])
    else $error("continuous stream stopped early");

  AST_TXW_8: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fabric_w == TRC_FW_8 && !pcie_mode) |=> (txw_out[0].data[7:0] == $past(tx_packed[7:0]))
      && (txw_out[0].disp_val[0] == $past(tx_packed[10])))
    else $error("8-bit transmit word decode wrong");

  AST_TXW_16: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fabric_w == TRC_FW_16) |=> (txw_out[0].data[15:8] == $past(tx_packed[18:11]))
      && (txw_out[0].ctrl[1] == $past(tx_packed[19])))
    else $error("16-bit transmit word decode wrong");

  AST_TXW_10: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fabric_w == TRC_FW_10) |=> (txw_out[0].data[9:0] == $past(tx_packed[9:0]))
      && (txw_out[0].data[19:10] == 10'h000))
    else $error("10-bit transmit word decode wrong");

  AST_TXW_16_PCIE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fabric_w == TRC_FW_16 && pcie_mode) |=> (txw_out[0].elec_idle == $past(tx_packed[10] | tx_packed[21]))
      && (txw_out[0].force_disp == 2'h0))
    else $error("16-bit transmit word idle decode wrong");

  AST_TXW_20: assert property (@(posedge core_clk) disable iff (sys_rst)
    (fabric_w == TRC_FW_20) |=> (txw_out[NUM_CH-1].data[19:10]
      == $past(tx_packed[(NUM_CH-1)*`TRC_TXP_W+`TRC_TXP_HI10_MSB -: 10])))
    else $error("20-bit transmit word high symbol wrong");

  AST_RX_COPY: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (rx_packed == $past(rx_chan_word)))
    else $error("packed receive word not passed through");

  AST_BOTH_REFUSED: assert property (@(posedge core_clk) disable iff (sys_rst)
    (idle && write_all && read) |=> !busy)
    else $error("read and write together were accepted");

  AST_STRM_PMA_KEPT: assert property (@(posedge core_clk) disable iff (sys_rst)
    strm_step |=> $stable(pma_set))
    else $error("word streaming changed analog settings");

  sequence s_last_out;
    cfg_done && cfg_word_valid ##1 !cfg_word_valid;
  endsequence

  AST_LAST_WORD: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strm_step && last_word) |=> s_last_out)
    else $error("last streamed word not flagged done");

endmodule : trc_ctrl
`default_nettype wire

//--- inc/trc_defines.svh
// Purpose: Constants for the transceiver reconfiguration controller
// Assumes: Single core clock domain
// Notes: Field positions refer to the packed transmit word
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH
`define TRC_SWING_W 3
`define TRC_PREEMP_W 5
`define TRC_DCGAIN_W 2
`define TRC_EQCTL_W 4
`define TRC_PMA_W 14
`define TRC_PMA_RST 14'h0000
`define TRC_CFG_WORD_W 16
`define TRC_TXP_W 22
`define TRC_RXP_W 32
`define TRC_DIR_RX 2'b01
`define TRC_DIR_TX 2'b10
`define TRC_DIR_DUPLEX 2'b11
`define TRC_WR_CYC_PER_CH 4
`define TRC_RD_CYC_PER_CH 3
`define TRC_TXP_CTRL_LO 8
`define TRC_TXP_FDISP_LO 9
`define TRC_TXP_DVAL_LO 10
`define TRC_TXP_HI_LSB 11
`define TRC_TXP_HI8_MSB 18
`define TRC_TXP_CTRL_HI 19
`define TRC_TXP_FDISP_HI 20
`define TRC_TXP_DVAL_HI 21
`define TRC_TXP_HI10_MSB 20
`endif

//--- inc/trc_pkg.sv
// Purpose: Types for the transceiver reconfiguration controller
// Assumes: trc_defines.svh on the include path
// Notes: Structs carry per-channel settings and decoded transmit words
`include "trc_defines.svh"
package trc_pkg;
  typedef enum logic [3:0] {
    TRC_ST_IDLE = 4'b0001,
    TRC_ST_WR = 4'b0010,
    TRC_ST_RD = 4'b0100,
    TRC_ST_STRM = 4'b1000
  } trc_state_t;
  typedef enum logic [1:0] {
    TRC_FW_8 = 2'b00,
    TRC_FW_10 = 2'b01,
    TRC_FW_16 = 2'b10,
    TRC_FW_20 = 2'b11
  } trc_fabric_w_t;
  typedef struct packed {
    logic [`TRC_SWING_W-1:0] swing;
    logic [`TRC_PREEMP_W-1:0] preemp;
    logic [`TRC_DCGAIN_W-1:0] dcgain;
    logic [`TRC_EQCTL_W-1:0] eqctl;
  } trc_pma_t;
  typedef struct packed {
    logic [19:0] data;
    logic [1:0] ctrl;
    logic [1:0] force_disp;
    logic [1:0] disp_val;
    logic compliance;
    logic elec_idle;
  } trc_txw_t;
endpackage : trc_pkg

//--- dv/trc_host_model.sv
// Purpose: Fabric-side requester for the reconfiguration controller
// Assumes: One request per go pulse from the bench
// Notes: Both goes together give both strobes, for refusal tests
`timescale 1ns/1ps
`default_nettype none
module trc_host_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic go_wr,
  input wire logic go_rd,
  input wire logic busy,
  output logic write_all,
  output logic read
);
  logic idle;
  // Only while idle, one-cycle strobe
  assign idle = !busy && !write_all && !read;
  // All-channel writes only, addressed method not modelled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      write_all <= 1'b0;
      read <= 1'b0;
    end else begin
      write_all <= go_wr && idle; // Write strobe
      read <= go_rd && idle; // Both only when bench asks
    end
  end
endmodule : trc_host_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for trc_ctrl
// Assumes: Two channels, per-channel writes, continuous streaming
// Notes: Requests pass through trc_host_model
`timescale 1ns/1ps
`default_nettype none
module tb
  import trc_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go_wr = 1'b0;
  logic go_rd = 1'b0;
  logic write_all;
  logic read;
  logic busy;
  logic data_valid;
  logic [1:0] dir_sel = 2'b11;
  logic chan_reconfig_mode = 1'b0;
  logic [5:0] swing_wr = '0;
  logic [9:0] preemp_wr = '0;
  logic [3:0] dcgain_wr = '0;
  logic [7:0] eqctl_wr = '0;
  logic [5:0] swing_rd;
  logic [9:0] preemp_rd;
  logic [3:0] dcgain_rd;
  logic [7:0] eqctl_rd;
  trc_pma_t [1:0] pma_set;
  logic img_we = 1'b0;
  logic [5:0] img_addr = '0;
  logic [15:0] img_data = '0;
  logic [6:0] img_len = '0;
  logic [15:0] cfg_word;
  logic [5:0] cfg_word_idx;
  logic cfg_word_valid;
  logic cfg_done;
  logic [43:0] tx_packed = '0;
  trc_fabric_w_t fabric_w = TRC_FW_8;
  logic pcie_mode = 1'b0;
  trc_txw_t [1:0] txw_out;
  logic [63:0] rx_chan_word = '0;
  logic [63:0] rx_packed;
  logic [22:0] wq [$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2.5 core_clk = ~core_clk;

  trc_host_model trc_host_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .go_wr(go_wr), .go_rd(go_rd),
    .busy(busy), .write_all(write_all), .read(read));

  trc_ctrl #(.NUM_CH(2), .PER_CH_WR(1'b1), .CONT_WR(1'b1), .IMG_AW(6)) trc_ctrl_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .write_all(write_all), .read(read), .dir_sel(dir_sel),
    .chan_reconfig_mode(chan_reconfig_mode), .swing_wr(swing_wr), .preemp_wr(preemp_wr),
    .dcgain_wr(dcgain_wr), .eqctl_wr(eqctl_wr), .swing_rd(swing_rd), .preemp_rd(preemp_rd),
    .dcgain_rd(dcgain_rd), .eqctl_rd(eqctl_rd), .busy(busy), .data_valid(data_valid), .pma_set(pma_set),
    .img_we(img_we), .img_addr(img_addr), .img_data(img_data), .img_len(img_len), .cfg_word(cfg_word),
    .cfg_word_idx(cfg_word_idx), .cfg_word_valid(cfg_word_valid), .cfg_done(cfg_done),
    .tx_packed(tx_packed), .fabric_w(fabric_w), .pcie_mode(pcie_mode), .txw_out(txw_out),
    .rx_chan_word(rx_chan_word), .rx_packed(rx_packed));

  function automatic logic [27:0] mrg(logic [27:0] o, logic [27:0] n, logic [1:0] d);
    for (int c = 0; c < 2; c++) begin
      if (d[1]) o[14*c+6 +: 8] = n[14*c+6 +: 8];
      if (d[0]) o[14*c +: 6] = n[14*c +: 6];
    end
    return o;
  endfunction : mrg

  function automatic logic [27:0] pk(logic [5:0] s, logic [9:0] p, logic [3:0] g, logic [7:0] e);
    return {s[5:3], p[9:5], g[3:2], e[7:4], s[2:0], p[4:0], g[1:0], e[3:0]};
  endfunction : pk

  function automatic trc_txw_t txe(logic [21:0] w, trc_fabric_w_t f, logic pc);
    trc_txw_t t;
    t = '0;
    case (f)
      TRC_FW_8: begin
        t.data = {12'h000, w[7:0]};
        t.ctrl = {1'b0, w[8]};
        if (pc) {t.compliance, t.elec_idle} = {w[9], w[10]};
        else {t.force_disp, t.disp_val} = {1'b0, w[9], 1'b0, w[10]};
      end
      TRC_FW_10: t.data = {10'h000, w[9:0]};
      TRC_FW_16: begin
        t.data = {4'h0, w[18:11], w[7:0]};
        t.ctrl = {w[19], w[8]};
        if (pc) {t.compliance, t.elec_idle} = {w[9], w[10] | w[21]};
        else {t.force_disp, t.disp_val} = {w[20], w[9], w[21], w[10]};
      end
      default: t.data = {w[20:11], w[9:0]};
    endcase
    return t;
  endfunction : txe

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic run(input logic w, input logic rq, output int nb);
    go_wr <= w;
    go_rd <= rq;
    @(posedge core_clk);
    go_wr <= 1'b0;
    go_rd <= 1'b0;
    nb = 0;
    for (int t = 0; t < 30 && !(nb > 0 && busy === 1'b0); t++) begin
      @(posedge core_clk);
      #1;
      if (busy === 1'b1) nb++;
    end
    @(posedge core_clk);
  endtask : run

  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Collect streamed words
  always @(posedge core_clk) begin
    if (cfg_word_valid === 1'b1) wq.push_back({cfg_done, cfg_word_idx, cfg_word});
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    logic [27:0] pm;
    logic [27:0] rdm;
    logic [31:0] r;
    logic [15:0] img [3];
    int nb;
    r = $urandom(32'hf555_d942);
    pm = '0;
    rdm = '0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk(busy, 1'b0); // Idle after reset
    chk(pma_set, pm); // Cleared settings
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      swing_wr <= r[5:0];
      preemp_wr <= r[15:6];
      dcgain_wr <= r[19:16];
      eqctl_wr <= r[27:20];
      dir_sel <= 2'(3 - k);
      run(1'b1, 1'b0, nb);
      chk(nb, 8); // Write busy span
      chk(data_valid, 1'b0); // Valid cleared by write
      pm = mrg(pm, pk(swing_wr, preemp_wr, dcgain_wr, eqctl_wr), dir_sel);
      chk(pma_set, pm); // Fields per channel
      run(1'b0, 1'b1, nb);
      chk(nb, 6); // Read busy span
      chk(data_valid, 1'b1); // Valid after read
      rdm = mrg(rdm, pm, dir_sel);
      chk(pk(swing_rd, preemp_rd, dcgain_rd, eqctl_rd), rdm); // Readback fields
    end
    $display("test analog write and read done");
    dir_sel <= 2'b11;
    run(1'b0, 1'b1, nb);
    r = $urandom;
    swing_wr <= {r[2:0], swing_rd[2:0]}; // Resupply channel 0
    preemp_wr <= preemp_rd;
    dcgain_wr <= dcgain_rd;
    eqctl_wr <= eqctl_rd;
    run(1'b1, 1'b0, nb);
    pm[25 +: 3] = r[2:0];
    chk(pma_set, pm); // Only channel 1 moved
    run(1'b1, 1'b1, nb);
    chk(nb, 0); // Both strobes ignored
    chk(pma_set, pm); // Settings kept
    chan_reconfig_mode <= 1'b1;
    run(1'b0, 1'b1, nb);
    chk(nb, 0); // No read in channel mode
    $display("test single channel and refusals done");
    for (int i = 0; i < 3; i++) begin
      img[i] = 16'($urandom);
      img_we <= 1'b1;
      img_addr <= 6'(i);
      img_data <= img[i];
      @(posedge core_clk);
    end
    img_we <= 1'b0;
    img_len <= 7'h03;
    run(1'b1, 1'b0, nb);
    @(posedge core_clk);
    chk(nb, 3); // One busy cycle per word
    chk(wq.size(), 3); // Word count
    for (int i = 0; i < 3; i++) chk(wq[i], {i == 2, 6'(i), img[i]}); // Word order
    chk(pma_set, pm); // Analog untouched
    img_len <= 7'h00;
    run(1'b1, 1'b0, nb);
    chk(nb, 0); // Empty image refused
    chk(wq.size(), 3); // No extra words
    $display("test stream done");
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      fabric_w <= trc_fabric_w_t'(r[1:0]);
      pcie_mode <= r[2] & ~r[0];
      tx_packed <= {r[31:10], 22'($urandom)};
      rx_chan_word <= {$urandom, r};
      @(posedge core_clk);
      @(posedge core_clk);
      chk(txw_out, {txe(tx_packed[43:22], fabric_w, pcie_mode),
        txe(tx_packed[21:0], fabric_w, pcie_mode)}); // Decode
      chk(rx_packed, rx_chan_word); // Receive copy
    end
    $display("test packed words done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
